// *** inc/pmc_pkg.sv ***
/*
  Package for the power mode controller: register map, field layout,
  reset values, key values and the structs that carry its signals.
  Assumes a 32-bit AXI4-Lite register bus; offsets are byte addresses.
*/
package pmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [31:0] MODE_SELECT_ADDR = 32'h4000_2400;
  localparam logic [31:0] UNLOCK_KEY_ADDR  = 32'h4000_2404;
  localparam logic [31:0] DEBUG_HOLD_ADDR  = 32'h4000_2408;
  localparam logic [31:0] STATUS_ADDR      = 32'h4000_240C;

  // field layout and reset values
  localparam int          MODE_LSB         = 0;
  localparam int          MODE_MSB         = 1;
  localparam int          REG_WIDTH        = 16;
  localparam logic [1:0]  MODE_RESET       = 2'h0;
  localparam logic [15:0] KEY_RESET        = 16'h0000;
  localparam logic [15:0] KEY_FIRST        = 16'h4859;
  localparam logic [15:0] KEY_SECOND       = 16'hF27B;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // power modes
  typedef enum logic [1:0] {
    MODE_ACTIVE     = 2'h0,
    MODE_CORE_GATED = 2'h1,
    MODE_BUS_GATED  = 2'h2,
    MODE_HIBERNATE  = 2'h3
  } power_mode_t;

  // clock and power controls towards the chip
  typedef struct packed {
    logic core_clk_en;
    logic bus_clk_en;
    logic periph_clk_en;
    logic free_clk_en;
    logic logic_power_en;
    logic retain;
    logic auto_gate_en;
  } power_ctrl_t;

  // sleep and wake signals from the core and interrupt controller
  typedef struct packed {
    logic core_sleeping;
    logic deep_sleep;
    logic in_handler;
    logic wake_irq;
    logic wake_irq_higher;
    logic wake_hib_source;
  } core_status_t;

endpackage : pmc_pkg

// *** rtl/power_mode_controller.sv ***
/*
  Power mode controller: key-protected mode register behind AXI4-Lite,
  a sleep-state machine that gates core, bus and free-running clocks,
  and the hibernate power and retention controls.
  Assumes the core reports sleep on core_status and wake events arrive
  synchronous to aclk; debug hold bits are cleared by por_n only.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
// Function
// - any wake from a low-power mode returns to active with everything clocked
// - mode 1 after core sleep gates only the core clock
// - mode 1 keeps free-running clock on; wake comes via interrupt controller
// - mode 2 after core sleep gates system bus and peripheral bus clocks
// - mode 2 keeps free-running clock for the interrupt controller
// - mode 3 removes logic power, retains state, stops free-running clock; here only on deep sleep, else it gates as mode 2
// - hibernate is left only by the fixed hibernate wake sources; when entered in a handler, here only a higher priority irq leaves it
// - entered inside a handler, leave only on reset or higher priority irq
// - debug hold bits cleared only by power-on reset
// - wait-for-interrupt alone sleeps only the core when mode is active
// - automatic clock gating stays enabled in every mode
// - mode field bits 1:0, 00 active to 11 hibernate, reset 0
// - mode register changes only after two successive key writes
// - unlock is 0x4859 then 0xF27B to key register, then mode write
// - any other register write after the keys relocks the mode register
`timescale 1ns/10ps
module power_mode_controller
  import pmc_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         por_n,
  input  wire logic [31:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [31:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire core_status_t core_status,
  output power_ctrl_t       power_ctrl,
  output logic              debug_hold
);

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture: address and data taken in either order
  logic [31:0] aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [1:0]  w_strb;
  logic        w_held;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held;

  // hold each channel until its partner arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb[1:0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // address decode for the write; a partial low half loads neither key nor mode
  wire [31:0] wa          = {aw_addr[31:2], 2'h0};
  wire        hit_mode_w  = wa == MODE_SELECT_ADDR;
  wire        hit_key_w   = wa == UNLOCK_KEY_ADDR;
  wire        hit_dbg_w   = wa == DEBUG_HOLD_ADDR;
  wire        hit_stat_w  = wa == STATUS_ADDR;
  wire        mapped_w    = hit_mode_w || hit_key_w || hit_dbg_w || hit_stat_w;
  wire        full_half   = w_strb == 2'h3;
  wire [15:0] wr_half     = w_data[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence
  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_HALF,
    KEY_OPEN
  } key_state_t;

  key_state_t  key_state;
  key_state_t  next_key_state;
  logic [15:0] key_reg;
  power_mode_t mode_reg;

  wire mode_write_ok = do_write && hit_mode_w && full_half && key_state == KEY_OPEN;

  // key walk: wrong key restarts, any other write relocks
  always_comb begin
    next_key_state = key_state;
    if (do_write) begin
      if (hit_key_w && full_half) begin
        case (key_state)
          KEY_LOCKED: next_key_state = (wr_half == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
          KEY_HALF: next_key_state = (wr_half == KEY_SECOND) ? KEY_OPEN :
                                     (wr_half == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
          default: next_key_state = (wr_half == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
        endcase
      end else begin
        next_key_state = KEY_LOCKED;
      end
    end
  end

  // key and mode registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_state <= KEY_LOCKED;
      key_reg   <= KEY_RESET;
      mode_reg  <= power_mode_t'(MODE_RESET);
    end else begin
      key_state <= next_key_state;
      if (do_write && hit_key_w && full_half) begin
        key_reg <= wr_half;
      end
      if (mode_write_ok) begin
        mode_reg <= power_mode_t'(wr_half[MODE_MSB:MODE_LSB]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // debug hold bit: survives system reset, cleared by power-on only
  // por_n is taken synchronous; it must be held across at least one edge
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      debug_hold <= 1'b0;
    end else if (do_write && hit_dbg_w && w_strb[0]) begin
      debug_hold <= w_data[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep state machine
  typedef enum logic [2:0] {
    ST_RUN,
    ST_CORE_GATED,
    ST_BUS_GATED,
    ST_HIBERNATE
  } sleep_state_t;

  sleep_state_t state;
  sleep_state_t next_state;
  logic         entered_in_handler;

  // a handler-time entry can only be left by a higher priority interrupt
  wire wake_irq_ok = entered_in_handler ? core_status.wake_irq_higher
                                        : core_status.wake_irq;
  wire wake_hib_ok = entered_in_handler ? core_status.wake_irq_higher
                                        : core_status.wake_hib_source;

  // mode active: plain core sleep never leaves run; debug hold blocks entry
  wire sleep_go = core_status.core_sleeping && !debug_hold;

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (sleep_go) begin
          case (mode_reg)
            MODE_CORE_GATED: next_state = ST_CORE_GATED;
            MODE_BUS_GATED:  next_state = ST_BUS_GATED;
            MODE_HIBERNATE:  next_state = core_status.deep_sleep ? ST_HIBERNATE
                                                                 : ST_BUS_GATED;
            default:         next_state = ST_RUN;
          endcase
        end
      end
      ST_CORE_GATED: next_state = wake_irq_ok ? ST_RUN : ST_CORE_GATED;
      ST_BUS_GATED:  next_state = wake_irq_ok ? ST_RUN : ST_BUS_GATED;
      ST_HIBERNATE:  next_state = wake_hib_ok ? ST_RUN : ST_HIBERNATE;
      default:       next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state              <= ST_RUN;
      entered_in_handler <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_RUN && next_state != ST_RUN) begin
        entered_in_handler <= core_status.in_handler;
      end
    end
  end

  // clock and power enables from state; auto gating always on
  always_comb begin
    power_ctrl                = '0;
    power_ctrl.auto_gate_en   = 1'b1;
    power_ctrl.core_clk_en    = state == ST_RUN;
    power_ctrl.bus_clk_en     = state == ST_RUN || state == ST_CORE_GATED;
    power_ctrl.periph_clk_en  = state == ST_RUN || state == ST_CORE_GATED;
    power_ctrl.free_clk_en    = state != ST_HIBERNATE;
    power_ctrl.logic_power_en = state != ST_HIBERNATE;
    power_ctrl.retain         = state == ST_HIBERNATE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped_w ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle to data
  wire [31:0] ra         = {s_axi_araddr[31:2], 2'h0};
  wire [31:0] stat_word  = {27'h0, entered_in_handler, key_state == KEY_OPEN, state};
  wire [31:0] rd_word    = (ra == MODE_SELECT_ADDR) ? {30'h0, mode_reg} :
                           (ra == UNLOCK_KEY_ADDR)  ? {16'h0, key_reg} :
                           (ra == DEBUG_HOLD_ADDR)  ? {31'h0, debug_hold} :
                           (ra == STATUS_ADDR)      ? stat_word : 32'h0000_0000;
  wire        mapped_r   = ra == MODE_SELECT_ADDR || ra == UNLOCK_KEY_ADDR ||
                           ra == DEBUG_HOLD_ADDR || ra == STATUS_ADDR;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= mapped_r ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_mode_locked;
    @(posedge aclk) disable iff (!aresetn)
      (key_state != KEY_OPEN) |=> $stable(mode_reg);
  endproperty
  a_mode_locked: assert property (p_mode_locked) else $error("mode changed while locked");

  property p_unlock_seq;
    @(posedge aclk) disable iff (!aresetn)
      (key_state == KEY_OPEN) |-> $past(key_state) inside {KEY_HALF, KEY_OPEN};
  endproperty
  a_unlock_seq: assert property (p_unlock_seq) else $error("unlock without first key");

  property p_relock;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && !hit_key_w) |=> key_state == KEY_LOCKED;
  endproperty
  a_relock: assert property (p_relock) else $error("other write did not relock");

  property p_bad_key;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && hit_key_w && full_half && wr_half != KEY_FIRST && wr_half != KEY_SECOND)
      |=> key_state == KEY_LOCKED;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key did not restart");

  property p_mode_readback;
    @(posedge aclk) disable iff (!aresetn)
      mode_write_ok |=> mode_reg == power_mode_t'($past(wr_half[1:0]));
  endproperty
  a_mode_readback: assert property (p_mode_readback) else $error("mode not stored");

  property p_core_gated;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_CORE_GATED) |-> !power_ctrl.core_clk_en && power_ctrl.bus_clk_en
                                   && power_ctrl.free_clk_en;
  endproperty
  a_core_gated: assert property (p_core_gated) else $error("mode 1 gating wrong");

  property p_bus_gated;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_BUS_GATED) |-> !power_ctrl.bus_clk_en && !power_ctrl.periph_clk_en
                                  && power_ctrl.free_clk_en;
  endproperty
  a_bus_gated: assert property (p_bus_gated) else $error("mode 2 gating wrong");

  property p_hibernate;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_HIBERNATE) |-> power_ctrl.retain && !power_ctrl.logic_power_en
                                  && !power_ctrl.free_clk_en;
  endproperty
  a_hibernate: assert property (p_hibernate) else $error("hibernate controls wrong");

  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
      (state != ST_RUN && (state == ST_HIBERNATE ? wake_hib_ok : wake_irq_ok))
      |=> state == ST_RUN && power_ctrl.core_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not return to active");

  property p_handler_wake;
    @(posedge aclk) disable iff (!aresetn)
      (state != ST_RUN && entered_in_handler && !core_status.wake_irq_higher)
      |=> $stable(state);
  endproperty
  a_handler_wake: assert property (p_handler_wake) else $error("handler sleep left early");

  property p_wfi_active;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_RUN && mode_reg == MODE_ACTIVE) |=> state == ST_RUN;
  endproperty
  a_wfi_active: assert property (p_wfi_active) else $error("active mode left run");

endmodule // power_mode_controller

// *** testbench/core_model.sv ***
/*
  Partner model of the core and interrupt controller: drives sleep and
  wake levels into the power mode controller on bench commands.
  Assumes commands are one-cycle pulses aligned to aclk.
*/
`timescale 1ns/10ps
module core_model
  import pmc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       sleep_cmd,
  input  wire logic       deep_cmd,
  input  wire logic       handler_cmd,
  input  wire logic [2:0] wake_cmd,
  output core_status_t    core_status
);
  ////////////////////////////////////////////////////////////////////////////
  // wake levels last one cycle; the core wakes on a hibernate source or higher
  // priority wake, and on a plain wake only outside a handler and deep sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_status <= '0;
    end else begin
      core_status.wake_irq        <= wake_cmd[0];
      core_status.wake_irq_higher <= wake_cmd[1];
      core_status.wake_hib_source <= wake_cmd[2];
      if (sleep_cmd) begin
        core_status.core_sleeping <= 1'b1;
        core_status.deep_sleep    <= deep_cmd;
        core_status.in_handler    <= handler_cmd;
      end else if (wake_cmd[2] || wake_cmd[1] || (wake_cmd[0] &&
                   !core_status.in_handler && !core_status.deep_sleep)) begin
        core_status.core_sleeping <= 1'b0;
        core_status.deep_sleep    <= 1'b0;
        core_status.in_handler    <= 1'b0;
      end
    end
  end
endmodule // core_model

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the power mode controller: AXI4-Lite master,
  core partner model, queue of expected results checked by a watcher.
  Assumes the controller answers within a few cycles of each request.
*/
`timescale 1ns/10ps
module tb_top
  import pmc_pkg::*;
  ();
  typedef struct {
    string       name;
    logic [31:0] exp;
    logic [31:0] mask;
    logic [1:0]  resp;
  } note_t;
  note_t        notes[$];
  logic         aclk, aresetn, por_n, snap;
  logic [31:0]  awaddr, wdata, araddr, rdata;
  logic         awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid, debug_hold;
  logic [1:0]   bresp, rresp;
  logic         sleep_cmd, deep_cmd, handler_cmd;
  logic [3:0]   wstrb;
  logic [2:0]   wake_cmd;
  core_status_t core_status;
  power_ctrl_t  power_ctrl;
  int           fails, checks, cycles, seed;
  // {debug_hold, power_ctrl} seen in each sleep state, and bits that matter
  logic [7:0]   state_exp[4] = '{8'h7D, 8'h3D, 8'h0D, 8'h03};
  logic [7:0]   state_mask[4] = '{8'h7F, 8'h7F, 8'h3F, 8'h0F};

  power_mode_controller i_dut (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_status(core_status),
    .power_ctrl(power_ctrl), .debug_hold(debug_hold));

  core_model i_core (
    .aclk(aclk), .aresetn(aresetn), .sleep_cmd(sleep_cmd), .deep_cmd(deep_cmd),
    .handler_cmd(handler_cmd), .wake_cmd(wake_cmd), .core_status(core_status));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watcher: oldest note against whatever result the design shows
  always @(posedge aclk) begin
    if (bvalid && bready) compare(32'h0, bresp);
    if (rvalid && rready) compare(rdata, rresp);
    if (snap) compare({24'h0, debug_hold, power_ctrl}, notes[0].resp);
  end

  task automatic compare(input logic [31:0] seen, input logic [1:0] rsp);
    note_t n;
    n = notes.pop_front();
    checks++;
    if (((seen ^ n.exp) & n.mask) !== 32'h0 || rsp !== n.resp) begin
      fails++;
      $display("MISMATCH %s expected %h/%h seen %h/%h", n.name, n.exp, n.resp, seen, rsp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // write: address and data offered together, bready held to the answer
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    int n;
    n = 0;
    notes.push_back('{"bresp", 32'h0, 32'h0, r});
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (!bvalid) fails++;
    bready <= 1'b0;
    step(1);
  endtask

  task automatic rd(input string nm, input logic [31:0] a, e, m, input logic [1:0] r);
    int n;
    n = 0;
    notes.push_back('{nm, e, m, r});
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (!rvalid) fails++;
    rready <= 1'b0;
    step(1);
  endtask

  task automatic expect_state(input string nm, input logic [7:0] e, m);
    notes.push_back('{nm, {24'h0, e}, {24'h0, m}, 2'h0});
    snap <= 1'b1;
    step(1);
    snap <= 1'b0;
    step(1);
  endtask

  task automatic set_mode(input logic [1:0] m);
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_FIRST}, RESP_OKAY);
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_SECOND}, RESP_OKAY);
    wr(MODE_SELECT_ADDR, {30'h0, m}, RESP_OKAY);
  endtask

  task automatic sleep(input logic deep, hnd);
    {deep_cmd, handler_cmd, sleep_cmd} <= {deep, hnd, 1'b1};
    step(1);
    sleep_cmd <= 1'b0;
    step(2);
  endtask

  // wake pulse, then a random settle gap
  task automatic wake(input logic [2:0] w);
    wake_cmd <= w;
    step(1);
    wake_cmd <= 3'h0;
    step(2 + ($random(seed) & 3));
  endtask

  task automatic test_done;
    if (notes.size() != 0) fails++;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {seed, fails, checks, cycles} = {32'd14, 96'h0};
    {aresetn, por_n, snap, sleep_cmd, deep_cmd, handler_cmd, wake_cmd} = '0;
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    step(8);
    {aresetn, por_n} <= 2'h3;
    step(1);
    rd("mode", MODE_SELECT_ADDR, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
    rd("key", UNLOCK_KEY_ADDR, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
    rd("hole", 32'h4000_2410, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
    expect_state("run", 8'h7D, 8'hFF);
    $display("test reset done");
    // locked write, broken key walk, foreign write between keys and mode write
    wr(MODE_SELECT_ADDR, 32'h1, RESP_OKAY);
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_FIRST}, RESP_OKAY);
    wr(UNLOCK_KEY_ADDR, $random(seed) & 32'hFFFE, RESP_OKAY);
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_SECOND}, RESP_OKAY);
    wr(MODE_SELECT_ADDR, 32'h2, RESP_OKAY);
    rd("mode", MODE_SELECT_ADDR, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_FIRST}, RESP_OKAY);
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_SECOND}, RESP_OKAY);
    rd("key", UNLOCK_KEY_ADDR, {16'h0, KEY_SECOND}, 32'hFFFF, RESP_OKAY);
    wr(32'h4000_2410, 32'h0, RESP_SLVERR);
    wr(MODE_SELECT_ADDR, 32'h3, RESP_OKAY);
    rd("mode", MODE_SELECT_ADDR, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
    // a key write with a partial strobe counts as a foreign write
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_FIRST}, RESP_OKAY);
    wstrb <= 4'h1;
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_SECOND}, RESP_OKAY);
    wstrb <= 4'hF;
    wr(MODE_SELECT_ADDR, 32'h1, RESP_OKAY);
    rd("key", UNLOCK_KEY_ADDR, {16'h0, KEY_FIRST}, 32'hFFFF, RESP_OKAY);
    rd("mode", MODE_SELECT_ADDR, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
    $display("test lock done");
    // every mode: program, sleep, wake
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      rd("mode", MODE_SELECT_ADDR, m, 32'hFFFF_7FFF, RESP_OKAY);
      sleep(m == 3, 1'b0);
      expect_state("sleep", state_exp[m], state_mask[m]);
      if (m == 3) begin
        wake(3'h1);
        expect_state("hib", state_exp[3], state_mask[3]);
      end
      wake(m == 3 ? 3'h4 : 3'h1);
      expect_state("wake", 8'h7D, 8'h7F);
      $display("test mode %0d done", m);
    end
    // sleep entered from inside a handler; mode 3 without deep sleep falls back to mode 2
    set_mode(2'h3);
    sleep(1'b0, 1'b1);
    rd("stat", STATUS_ADDR, 32'h12, 32'hFFFF_FFFF, RESP_OKAY);
    wake(3'h1);
    expect_state("handler", state_exp[2], state_mask[2]);
    wake(3'h2);
    expect_state("wake", 8'h7D, 8'h7F);
    $display("test handler done");
    // debug hold survives the bus reset, only power-on reset clears it
    wr(DEBUG_HOLD_ADDR, 32'h1, RESP_OKAY);
    aresetn <= 1'b0;
    step(2);
    aresetn <= 1'b1;
    step(1);
    rd("dbg", DEBUG_HOLD_ADDR, 32'h1, 32'h1, RESP_OKAY);
    set_mode(2'h1);
    sleep(1'b0, 1'b0);
    expect_state("held", 8'hFD, 8'hFF);
    wake(3'h1);
    por_n <= 1'b0;
    step(2);
    por_n <= 1'b1;
    step(1);
    expect_state("por", 8'h7D, 8'hFF);
    $display("test debug done");
    test_done;
  end
endmodule // tb_top
